/* hw/cap_regs.vh */
// Constants for the camera serial command parser: characters, keywords,
// reset values and timing figures.
// Assumes a single 10 MHz system clock; included by bare name.
`ifndef CAP_REGS_VH
`define CAP_REGS_VH

// Timing
`define CAP_CLK_HZ        10000000
`define CAP_BAUD_BPS      9600
`define CAP_TIMEOUT_S     15
`define CAP_EXT_MIN_US    1000

// Characters
`define CAP_CH_CR         8'h0D
`define CAP_CH_LF         8'h0A
`define CAP_CH_EQ         8'h3D
`define CAP_CH_QM         8'h3F
`define CAP_CH_0          8'h30
`define CAP_CH_9          8'h39
`define CAP_CH_A_LO       8'h61
`define CAP_CH_Z_LO       8'h7A
`define CAP_CH_USCORE     8'h5F

// Reply letters
`define CAP_CH_O          8'h4F
`define CAP_CH_K          8'h4B
`define CAP_CH_N          8'h4E
`define CAP_CH_G          8'h47
`define CAP_CH_E          8'h45
`define CAP_CH_C          8'h43
`define CAP_CH_T          8'h54

// Keywords, right aligned in a 64-bit field
`define CAP_KW_CTRL       64'h000000006374726C
`define CAP_KW_DIPSW      64'h0000006469707377
`define CAP_KW_ID         64'h0000000000006964
`define CAP_KW_BIT        64'h0000000000626974
`define CAP_KW_SYNC       64'h0000000073796E63
`define CAP_KW_EXPC       64'h0000000065787063
`define CAP_KW_GAINPOS    64'h006761696E706F73

// Reset values of the settings
`define CAP_RST_CTRL      1'h0
`define CAP_RST_CAM       8'h00
`define CAP_RST_BIT10     1'h0
`define CAP_RST_SYNC      1'h0
`define CAP_RST_EXP       2'h0
`define CAP_RST_GAIN      4'h1

// Ranges
`define CAP_GAIN_MAX      4'h8
`define CAP_EXP_MAX       2'h2
`define CAP_KW_MAXLEN     4'h8
`define CAP_NUM_MAXDIG    3'h3

`endif

/* hw/cap_parser.v */
// Serial ASCII command parser for the camera settings, with its own
// receiver and transmitter on the serial pins.
// Assumes one 10 MHz clock and a host that waits for each reply.
`timescale 1ns/100ps
`include "cap_regs.vh"

// Contract
// - Serial link 9600 baud, start bit, eight data bits, one stop, no parity.
// - Keywords are lower case only; upper case makes the command invalid.
// - CR, LF or CR+LF end a command; every reply ends with CR only.
// - A bare keyword acts as its query; the question mark is optional.
// - Queries return the value; keyword=number sets it and replies OK.
// - Malformed or unknown commands get NG.
// - Out of range numbers get NE and the setting stays unchanged.
// - Setting a protected value while source select is 0 gets NC.
// - No terminator within 15 s of the first character gives TO.
// - Source select: 0 switches govern, 1 serial governs; read and write.
// - Switch readback returns the eight switches as decimal 0 to 255.
// - Output width 8 or 10, default 8, settable only with select 1.
// - Sync source 0 internal, 1 external line trigger; read and write.
// - External trigger period under 1 ms falls back to internal timing.
// - Exposure mode query returns 0, 1 or 2; effective only with select 1.
// - Gain position defaults to one, selectable up to eight.
// - Exposure mode set takes 0, 1 or 2, only while select is 1.
module cap_parser #(
  parameter TIMEOUT_CYC = `CAP_TIMEOUT_S * `CAP_CLK_HZ,
  parameter EXT_MIN_CYC = (`CAP_EXT_MIN_US * (`CAP_CLK_HZ / 1000)) / 1000,
  parameter BAUD_CYC    = (`CAP_CLK_HZ + `CAP_BAUD_BPS / 2) / `CAP_BAUD_BPS
) (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       ser_rx,
  output reg        ser_tx,
  input  wire [7:0] dip_sw,
  input  wire       ext_line_trig,
  output wire       ctrl_serial,
  output wire [7:0] cam_number,
  output wire       bit_width_10,
  output wire       sync_ext,
  output wire [1:0] exp_mode,
  output wire [3:0] gain_pos
);

  localparam HALF_CYC = BAUD_CYC / 2;

  localparam RX_IDLE  = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA  = 2'h2;
  localparam RX_STOP  = 2'h3;

  function is_digit;
    input [7:0] c;
    begin
      is_digit = (c >= `CAP_CH_0) && (c <= `CAP_CH_9);
    end
  endfunction

  // Decimal text of 0..255: count of digits, then up to three characters
  function [26:0] to_dec;
    input [7:0] v;
    reg   [7:0] h;
    reg   [7:0] t;
    reg   [7:0] o;
    begin
      h = v / 8'h64;
      t = (v / 8'h0A) % 8'h0A;
      o = v % 8'h0A;
      if (v >= 8'h64) begin
        to_dec = {3'h3, `CAP_CH_0 + h, `CAP_CH_0 + t, `CAP_CH_0 + o};
      end else if (v >= 8'h0A) begin
        to_dec = {3'h2, `CAP_CH_0 + t, `CAP_CH_0 + o, 8'h00};
      end else begin
        to_dec = {3'h1, `CAP_CH_0 + o, 16'h0000};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] rx_ff;
  reg [1:0] ext_ff;
  reg [7:0] dip_m;
  reg [7:0] dip_s;
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_ff  <= 2'h3;
      ext_ff <= 2'h0;
      dip_m  <= 8'h00;
      dip_s  <= 8'h00;
    end else begin
      rx_ff  <= {rx_ff[0], ser_rx};
      ext_ff <= {ext_ff[0], ext_line_trig};
      dip_m  <= dip_sw;
      dip_s  <= dip_m;
    end
  end
  wire rx_s  = rx_ff[1];
  wire ext_s = ext_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // Receiver
  reg [1:0]  rx_st;
  reg [10:0] rx_cnt;
  reg [2:0]  rx_bit;
  reg [7:0]  rx_sh;
  reg        rx_vld;
  reg [7:0]  rx_byte;
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_st   <= RX_IDLE;
      rx_cnt  <= 11'h000;
      rx_bit  <= 3'h0;
      rx_sh   <= 8'h00;
      rx_vld  <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_vld <= 1'b0;
      case (rx_st)
        RX_IDLE: begin
          rx_cnt <= 11'h000;
          if (!rx_s) begin
            rx_st <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt == HALF_CYC[10:0]) begin
            rx_cnt <= 11'h000;
            rx_bit <= 3'h0;
            // A glitch shorter than half a bit is not a start bit
            rx_st  <= rx_s ? RX_IDLE : RX_DATA;
          end else begin
            rx_cnt <= rx_cnt + 11'h001;
          end
        end
        RX_DATA: begin
          if (rx_cnt == BAUD_CYC[10:0] - 11'h001) begin
            rx_cnt <= 11'h000;
            rx_sh  <= {rx_s, rx_sh[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_st <= RX_STOP;
            end
          end else begin
            rx_cnt <= rx_cnt + 11'h001;
          end
        end
        RX_STOP: begin
          if (rx_cnt == BAUD_CYC[10:0] - 11'h001) begin
            rx_st <= RX_IDLE;
            // Framing errors drop the byte silently
            if (rx_s) begin
              rx_vld  <= 1'b1;
              rx_byte <= rx_sh;
            end
          end else begin
            rx_cnt <= rx_cnt + 11'h001;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter: rep_n characters of rep, then CR
  reg [31:0] rep;
  reg [2:0]  rep_n;
  reg        tx_busy;
  reg [2:0]  tx_idx;
  reg [9:0]  tx_sh;
  reg [3:0]  tx_bits;
  reg [10:0] tx_cnt;
  reg        tx_go;
  wire [7:0] tx_char = (tx_idx == rep_n) ? `CAP_CH_CR :
                       rep[31 - 8 * tx_idx -: 8];
  always @(posedge sys_clk) begin
    if (rst) begin
      ser_tx  <= 1'b1;
      tx_busy <= 1'b0;
      tx_idx  <= 3'h0;
      tx_sh   <= 10'h3FF;
      tx_bits <= 4'h0;
      tx_cnt  <= 11'h000;
    end else if (!tx_busy) begin
      ser_tx <= 1'b1;
      if (tx_go) begin
        tx_busy <= 1'b1;
        tx_idx  <= 3'h0;
        tx_bits <= 4'h0;
        tx_cnt  <= 11'h000;
      end
    end else if (tx_bits == 4'h0 && tx_cnt == 11'h000) begin
      tx_sh   <= {1'b1, tx_char, 1'b0};
      ser_tx  <= 1'b0;
      tx_cnt  <= 11'h001;
      tx_bits <= 4'h1;
    end else if (tx_cnt == BAUD_CYC[10:0]) begin
      tx_cnt <= 11'h001;
      if (tx_bits == 4'hA) begin
        tx_bits <= 4'h0;
        tx_cnt  <= 11'h000;
        tx_idx  <= tx_idx + 3'h1;
        if (tx_idx == rep_n) begin
          tx_busy <= 1'b0;
        end
      end else begin
        ser_tx  <= tx_sh[tx_bits];
        tx_bits <= tx_bits + 4'h1;
      end
    end else begin
      tx_cnt <= tx_cnt + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command collection
  reg [63:0] kw;
  reg [3:0]  klen;
  reg        seen_eq;
  reg        seen_q;
  reg        bad;
  reg        ovf;
  reg [9:0]  num;
  reg [2:0]  ndig;
  reg        active;
  reg        pend;
  reg        tmo;
  reg [31:0] tmo_cnt;

  // Settings
  reg       ctrl;
  reg [7:0] cam;
  reg       bit10;
  reg       sync_sel;
  reg [1:0] exp;
  reg [3:0] gain;

  wire is_term = (rx_byte == `CAP_CH_CR) || (rx_byte == `CAP_CH_LF);
  wire is_lc   = (rx_byte >= `CAP_CH_A_LO) && (rx_byte <= `CAP_CH_Z_LO);
  wire kw_char = is_lc || is_digit(rx_byte) || (rx_byte == `CAP_CH_USCORE);

  ////////////////////////////////////////////////////////////////////////
  // Evaluation of a finished command
  reg [2:0]  n_code;
  reg [7:0]  n_val;
  reg        n_apply;
  reg [26:0] dec;
  always @* begin
    n_val   = 8'h00;
    n_apply = 1'b0;
    n_code  = 3'h0;                              // 0 OK
    case (kw)
      `CAP_KW_CTRL:    n_val = {7'h00, ctrl};
      `CAP_KW_DIPSW:   n_val = dip_s;
      `CAP_KW_ID:      n_val = cam;
      `CAP_KW_BIT:     n_val = bit10 ? 8'h0A : 8'h08;
      `CAP_KW_SYNC:    n_val = {7'h00, sync_sel};
      `CAP_KW_EXPC:    n_val = {6'h00, exp};
      `CAP_KW_GAINPOS: n_val = {4'h0, gain};
      default:         n_code = 3'h1;
    endcase
    if (tmo) begin
      n_code = 3'h4;
    end else if (bad || n_code == 3'h1 || (seen_eq && ndig == 3'h0) ||
                 (seen_eq && kw == `CAP_KW_DIPSW)) begin
      n_code = 3'h1;
    end else if (!seen_eq) begin
      n_code = 3'h5;
    end else if (ovf ||
                 (kw == `CAP_KW_CTRL && num > 10'h001) ||
                 (kw == `CAP_KW_ID && num > 10'h0FF) ||
                 (kw == `CAP_KW_BIT && num != 10'h008 && num != 10'h00A) ||
                 (kw == `CAP_KW_SYNC && num > 10'h001) ||
                 (kw == `CAP_KW_EXPC && num > {8'h00, `CAP_EXP_MAX}) ||
                 (kw == `CAP_KW_GAINPOS &&
                  (num == 10'h000 || num > {6'h00, `CAP_GAIN_MAX}))) begin
      n_code = 3'h2;
    end else if (!ctrl && (kw == `CAP_KW_BIT || kw == `CAP_KW_EXPC ||
                           kw == `CAP_KW_GAINPOS)) begin
      n_code = 3'h3;
    end else begin
      n_apply = 1'b1;
    end
    dec = to_dec(n_val);
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      kw       <= 64'h0000000000000000;
      klen     <= 4'h0;
      seen_eq  <= 1'b0;
      seen_q   <= 1'b0;
      bad      <= 1'b0;
      ovf      <= 1'b0;
      num      <= 10'h000;
      ndig     <= 3'h0;
      active   <= 1'b0;
      pend     <= 1'b0;
      tmo      <= 1'b0;
      tmo_cnt  <= 32'h00000000;
      tx_go    <= 1'b0;
      rep      <= 32'h00000000;
      rep_n    <= 3'h0;
      ctrl     <= `CAP_RST_CTRL;
      cam      <= `CAP_RST_CAM;
      bit10    <= `CAP_RST_BIT10;
      sync_sel <= `CAP_RST_SYNC;
      exp      <= `CAP_RST_EXP;
      gain     <= `CAP_RST_GAIN;
    end else begin
      tx_go <= 1'b0;
      if (pend) begin
        // Wait for the previous reply to leave before loading this one
        if (!tx_busy && !tx_go) begin
          pend  <= 1'b0;
          tx_go <= 1'b1;
          case (n_code)
            3'h0: rep <= {`CAP_CH_O, `CAP_CH_K, 16'h0000};
            3'h1: rep <= {`CAP_CH_N, `CAP_CH_G, 16'h0000};
            3'h2: rep <= {`CAP_CH_N, `CAP_CH_E, 16'h0000};
            3'h3: rep <= {`CAP_CH_N, `CAP_CH_C, 16'h0000};
            3'h4: rep <= {`CAP_CH_T, `CAP_CH_O, 16'h0000};
            default: rep <= {dec[23:0], 8'h00};
          endcase
          rep_n <= (n_code == 3'h5) ? dec[26:24] : 3'h2;
          if (n_apply) begin
            case (kw)
              `CAP_KW_CTRL:    ctrl     <= num[0];
              `CAP_KW_ID:      cam      <= num[7:0];
              `CAP_KW_BIT:     bit10    <= num[1];
              `CAP_KW_SYNC:    sync_sel <= num[0];
              `CAP_KW_EXPC:    exp      <= num[1:0];
              `CAP_KW_GAINPOS: gain     <= num[3:0];
              default:         ctrl     <= ctrl;
            endcase
          end
          kw      <= 64'h0000000000000000;
          klen    <= 4'h0;
          seen_eq <= 1'b0;
          seen_q  <= 1'b0;
          bad     <= 1'b0;
          ovf     <= 1'b0;
          num     <= 10'h000;
          ndig    <= 3'h0;
          tmo     <= 1'b0;
        end
      end else if (active && tmo_cnt == TIMEOUT_CYC - 1) begin
        active <= 1'b0;
        pend   <= 1'b1;
        tmo    <= 1'b1;
      end else if (rx_vld) begin
        if (is_term) begin
          // The LF of a CR+LF pair finds no command open and is dropped
          if (active) begin
            active <= 1'b0;
            pend   <= 1'b1;
          end
        end else begin
          if (!active) begin
            tmo_cnt <= 32'h00000000;
          end
          active <= 1'b1;
          if (seen_q) begin
            bad <= 1'b1;
          end else if (seen_eq) begin
            if (!is_digit(rx_byte)) begin
              bad <= 1'b1;
            end else if (ndig == `CAP_NUM_MAXDIG) begin
              ovf <= 1'b1;
            end else begin
              num  <= num * 10'h00A + {2'h0, rx_byte - `CAP_CH_0};
              ndig <= ndig + 3'h1;
            end
          end else if (rx_byte == `CAP_CH_EQ) begin
            seen_eq <= 1'b1;
            bad     <= bad | (klen == 4'h0);
          end else if (rx_byte == `CAP_CH_QM) begin
            seen_q  <= 1'b1;
          end else if (kw_char && klen != `CAP_KW_MAXLEN) begin
            kw   <= {kw[55:0], rx_byte};
            klen <= klen + 4'h1;
          end else begin
            bad <= 1'b1;
          end
        end
      end
      if (active && !rx_vld) begin
        tmo_cnt <= tmo_cnt + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External line trigger period watch
  reg        ext_d;
  reg [31:0] per_cnt;
  reg        fallback;
  always @(posedge sys_clk) begin
    if (rst) begin
      ext_d    <= 1'b0;
      per_cnt  <= 32'h00000000;
      fallback <= 1'b0;
    end else begin
      ext_d <= ext_s;
      if (ext_s && !ext_d) begin
        per_cnt  <= 32'h00000000;
        fallback <= (per_cnt < EXT_MIN_CYC - 1);
      end else if (per_cnt != 32'hFFFFFFFF) begin
        per_cnt <= per_cnt + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective settings: width and gain follow the switches, exposure mode is 0, while select is 0
  assign ctrl_serial  = ctrl;
  assign cam_number   = cam;
  assign bit_width_10 = ctrl ? bit10 : dip_s[3];
  assign sync_ext     = sync_sel & ~fallback;
  assign exp_mode     = ctrl ? exp : `CAP_RST_EXP;
  assign gain_pos     = ctrl ? gain : {1'b0, dip_s[2:0]} + 4'h1;

endmodule

/* test/cap_parser_monitor.sv */
// Concurrent checks on the ports of the camera command parser.
// Assumes one clock, sys_clk, and a synchronous active-high rst.
`timescale 1ns/100ps
module cap_parser_monitor #(
  parameter int BIT_CYC = 1042
) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       ser_rx,
  input wire logic       ser_tx,
  input wire logic [7:0] dip_sw,
  input wire logic       ext_line_trig,
  input wire logic       ctrl_serial,
  input wire logic [7:0] cam_number,
  input wire logic       bit_width_10,
  input wire logic       sync_ext,
  input wire logic [1:0] exp_mode,
  input wire logic [3:0] gain_pos
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Length of the current low stretch on the transmit line
  logic [15:0] low_run;
  always @(posedge sys_clk) begin
    if (rst || ser_tx) begin
      low_run <= 16'h0000;
    end else if (low_run != 16'hFFFF) begin
      low_run <= low_run + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Five quiet cycles cover the two switch synchroniser stages
  sequence s_sw_quiet;
    (!ctrl_serial && $stable(dip_sw))[*5];
  endsequence
  property p_tx_idle; $fell(rst) |-> ser_tx; endproperty
  property p_rst_vals; $fell(rst) |-> cam_number == 8'h00 && !ctrl_serial; endproperty
  property p_exp_gate; !ctrl_serial |-> exp_mode == 2'h0; endproperty
  property p_exp_range; exp_mode != 2'h3; endproperty
  property p_width_sw; s_sw_quiet |-> bit_width_10 == dip_sw[3]; endproperty
  property p_gain_sw; s_sw_quiet |-> gain_pos == {1'b0, dip_sw[2:0]} + 4'h1; endproperty
  property p_set_reply;
    ($changed(cam_number) || $changed(ctrl_serial)) |-> ##[0:8] !ser_tx;
  endproperty
  // Every low stretch, start bit included, lasts at least one whole bit
  property p_tx_start; $rose(ser_tx) |-> low_run >= BIT_CYC; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx not idle after reset");
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset values");
  a_exp_gate: assert property (p_exp_gate) else $error("exposure mode not gated");
  a_exp_range: assert property (p_exp_range) else $error("exposure mode out of range");
  a_width_sw: assert property (p_width_sw) else $error("width not from switch");
  a_gain_sw: assert property (p_gain_sw) else $error("gain not from switches");
  a_set_reply: assert property (p_set_reply) else $error("set without reply");
  a_tx_start: assert property (p_tx_start) else $error("start bit too short");
  c_ctrl: cover property ($rose(ctrl_serial));
  c_exp2: cover property (exp_mode == 2'h2);
  c_fallback: cover property ($fell(sync_ext));
endmodule
bind cap_parser cap_parser_monitor #(.BIT_CYC(BAUD_CYC)) u_cap_parser_monitor (
  .sys_clk(sys_clk), .rst(rst),
  .ser_rx(ser_rx), .ser_tx(ser_tx), .dip_sw(dip_sw), .ext_line_trig(ext_line_trig),
  .ctrl_serial(ctrl_serial), .cam_number(cam_number), .bit_width_10(bit_width_10),
  .sync_ext(sync_ext), .exp_mode(exp_mode), .gain_pos(gain_pos));

/* test/cap_host_model.sv */
// Host terminal model: sends command text and collects replies.
// Assumes a 10 MHz sys_clk; serial lines idle high.
`timescale 1ns/100ps
module cap_host_model (
  input  wire logic sys_clk,
  input  wire logic ser_tx,
  output logic      ser_rx
);
  parameter int BIT_CYC = 1042;
  string reply_cur;
  string reply_last;
  int    n_replies;
  initial ser_rx = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      ser_rx = f[i];
      repeat (BIT_CYC - 1) @(negedge sys_clk);
    end
  endtask
  // Only single-byte characters, no blanks, from the caller's text
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) send_byte(s[i]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Sampling at mid bit tolerates the rounding of the bit time
  always begin : rx_proc
    logic [7:0] b;
    @(negedge ser_tx);
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      b[i] = ser_tx;
    end
    repeat (BIT_CYC) @(posedge sys_clk);
    if (b == 8'h0D) begin
      reply_last = reply_cur;
      reply_cur = "";
      n_replies++;
    end else begin
      reply_cur = $sformatf("%s%c", reply_cur, b);
    end
  end
endmodule

/* test/cap_parser_tb_top.sv */
// Self-checking bench for the camera command parser.
// Assumes the host model in cap_host_model and a 10 MHz clock.
`timescale 1ns/100ps
module cap_parser_tb_top;
  logic       sys_clk;
  logic       rst;
  logic [7:0] dip_sw;
  logic       ext_line_trig;
  wire        ser_rx;
  wire        ser_tx;
  wire        ctrl_serial;
  wire  [7:0] cam_number;
  wire        bit_width_10;
  wire        sync_ext;
  wire  [1:0] exp_mode;
  wire  [3:0] gain_pos;
  int         miscompares;
  int         n_checks;
  // Shortened counts keep the run bounded
  cap_parser #(.TIMEOUT_CYC(6000), .EXT_MIN_CYC(200), .BAUD_CYC(32)) u_cap_parser (
    .sys_clk(sys_clk), .rst(rst), .ser_rx(ser_rx), .ser_tx(ser_tx), .dip_sw(dip_sw),
    .ext_line_trig(ext_line_trig), .ctrl_serial(ctrl_serial), .cam_number(cam_number),
    .bit_width_10(bit_width_10), .sync_ext(sync_ext), .exp_mode(exp_mode),
    .gain_pos(gain_pos));
  cap_host_model #(.BIT_CYC(32)) u_cap_host_model (.sys_clk(sys_clk), .ser_tx(ser_tx),
    .ser_rx(ser_rx));
  string cmd_tab [17] = '{"id\015", "ctrl?\012", "bit\015\012", "bit=10\015",
    "ID\015", "chake\015", "dipsw\015", "gainpos=96\015", "ctrl=1\015",
    "bit=10\015", "bit?\015", "expc=3\015", "expc=2\015", "expc\015",
    "id=255\015", "sync=1\015", "gainpos=5\015"};
  string exp_tab [17] = '{"0", "0", "8", "NC", "NG", "NG", "173", "NE", "OK",
    "OK", "10", "NE", "OK", "2", "OK", "OK", "OK"};
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] s2v(input string s);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < s.len(); i++) v = {v[23:0], s[i]};
    return v;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic do_cmd(input string cmd, input string exp);
    int n0;
    int k;
    n0 = u_cap_host_model.n_replies;
    u_cap_host_model.send_str(cmd);
    for (k = 0; k < 10000 && u_cap_host_model.n_replies == n0; k++) @(negedge sys_clk);
    if (k == 10000) begin
      miscompares++;
      wrap_up();
    end
    check(s2v(u_cap_host_model.reply_last), s2v(exp));
    $display("test %s done", exp);
  endtask
  task automatic trig_run(input int per, input int n);
    repeat (n) begin
      ext_line_trig = 1'b1;
      repeat (per / 2) @(negedge sys_clk);
      ext_line_trig = 1'b0;
      repeat (per / 2) @(negedge sys_clk);
    end
    repeat (10) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    dip_sw = 8'hAD;
    ext_line_trig = 1'b0;
    miscompares = 0;
    n_checks = 0;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check(ser_tx, 1'b1);
    for (int r = 0; r < 17; r++) do_cmd(cmd_tab[r], exp_tab[r]);
    check({ctrl_serial, bit_width_10, sync_ext}, 3'h7);
    check({cam_number, exp_mode, gain_pos}, {8'hFF, 2'h2, 4'h5});
    // A partial command must be dropped and the next one parsed clean
    do_cmd("gainpo", "TO");
    do_cmd("id\015", "255");
    trig_run(100, 5);
    check(sync_ext, 1'b0);
    trig_run(400, 3);
    check(sync_ext, 1'b1);
    $display("test fallback done");
    repeat (2000) @(negedge sys_clk);
    check(u_cap_host_model.n_replies, 32'd19);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    check({ctrl_serial, cam_number, bit_width_10, exp_mode}, 12'h004);
    check(gain_pos, 4'h6);
    check(ser_tx, 1'b1);
    $display("test reset done");
    wrap_up();
  end
endmodule
